// ### shared/ssl_pkg.sv
// Constants, field positions and size codes of the substack limit controller.
// Assumes one clock domain shared with the processor core and the register port.
// Notes on behaviour
// RULE1 - A stack read below the underflow limit address raises underflow.
// RULE2 - A read or write at the fatal limit address raises fatal error.
// RULE3 - Error conditions stay set until software writes the pointer register.
// RULE4 - Writes wrap from the highest location back to the lowest.
// RULE5 - Reads wrap from the lowest location back to the highest.
// RULE6 - Each 256-word stack splits into 32, 64 or 128 word substacks.
// RULE7 - Size field sits at config bits 1-2 (parameter) and 9-10 (return).
// RULE8 - Pointer bits 5-7 and 13-15 select the substack when substacks exist.
// RULE9 - Select bits never count on push or pop; they hold the base.
// RULE10 - Software writes substack number and position together into the pointer.
// RULE11 - Start flag at config bit 0 (parameter) and bit 8 (return).
// RULE12 - Start flag one: stack begins at its bottom location 0.
// RULE13 - Start flag zero: stack begins at its midpoint (128, 64, 32, 16).
// RULE14 - Overflow limit below the middle forces a bottom start.
// RULE15 - A write at the overflow limit address raises overflow.
// RULE16 - Underflow limit at config bits 3-7 and 11-15; whole register accessed.
// RULE17 - Overflow limit register is write-only: parameter low byte, return high.
// RULE18 - Fatal errors of both stacks OR into one flag, cleared by pointer write.
package ssl_pkg;

  // ---------------------------------------------------------------
  // Register port addresses
  // ---------------------------------------------------------------
  localparam logic [4:0] SSL_ADDR_PTR  = 5'h09;
  localparam logic [4:0] SSL_ADDR_ULIM = 5'h0a;
  localparam logic [4:0] SSL_ADDR_OLIM = 5'h0b;

  // ---------------------------------------------------------------
  // Field layout within one stack's byte, plus data width, depth and stack count
  // ---------------------------------------------------------------
  localparam int SSL_BYTE_W     = 8;
  localparam int SSL_START_BIT  = 0;
  localparam int SSL_SIZE_LSB   = 1;
  localparam int SSL_ULIM_LSB   = 3;
  localparam int SSL_ULIM_W     = 5;
  localparam int SSL_DATA_W     = 16;
  localparam int SSL_DEPTH      = 256;
  localparam int SSL_NSTACK     = 2;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  SSL_PTR_RST  = 8'h00;
  localparam logic [15:0] SSL_ULIM_RST = 16'h0000;
  localparam logic [15:0] SSL_OLIM_RST = 16'h0000;

  // ---------------------------------------------------------------
  // Substack sizes and their address masks
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SSL_SZ32  = 2'b00,
    SSL_SZ64  = 2'b01,
    SSL_SZ128 = 2'b10,
    SSL_SZ256 = 2'b11
  } ssl_size_e;

  localparam logic [7:0] SSL_MASK32  = 8'h1f;
  localparam logic [7:0] SSL_MASK64  = 8'h3f;
  localparam logic [7:0] SSL_MASK128 = 8'h7f;
  localparam logic [7:0] SSL_MASK256 = 8'hff;
  localparam logic [7:0] SSL_ONE     = 8'h01;

endpackage

// ### design/ssl_limit_calc.sv
// Limit address derivation for one stack from its pointer and config bytes.
// Assumes purely combinational use by the controller on the same clock.
`timescale 1ns/1ps
module ssl_limit_calc (
  input  wire logic [7:0] ptr,
  input  wire logic [7:0] ulim_cfg,
  input  wire logic [7:0] olim,
  output logic      [7:0] mask,
  output logic      [7:0] start_loc,
  output logic      [7:0] fatal_lim,
  output logic      [7:0] ulim_addr,
  output logic      [7:0] olim_addr
);

  ssl_pkg::ssl_size_e size;
  logic               start_bottom;
  logic [7:0]         top;
  logic [7:0]         half;
  logic               mid;
  logic [7:0]         base;
  logic [7:0]         ufield;

  // ---------------------------------------------------------------
  // Size decode and limit addresses
  // ---------------------------------------------------------------
  // Upper pointer bits above the mask form the substack base
  always_comb begin
    size         = ssl_pkg::ssl_size_e'(ulim_cfg[ssl_pkg::SSL_SIZE_LSB +: 2]);   // RULE7
    start_bottom = ulim_cfg[ssl_pkg::SSL_START_BIT];                             // RULE11
    case (size)                                                                  // RULE6
      ssl_pkg::SSL_SZ32:  mask = ssl_pkg::SSL_MASK32;
      ssl_pkg::SSL_SZ64:  mask = ssl_pkg::SSL_MASK64;
      ssl_pkg::SSL_SZ128: mask = ssl_pkg::SSL_MASK128;
      default:            mask = ssl_pkg::SSL_MASK256;
    endcase
    half      = mask >> 1;
    top       = mask ^ half;
    base      = ptr & ~mask;                                                     // RULE8
    // Overflow limit below the middle means no midpoint start
    mid       = ((olim & top) != 8'h00) && !start_bottom;                        // RULE14
    start_loc = base | (mid ? top : 8'h00);                                      // RULE12 RULE13
    fatal_lim = base | (mask ^ (mid ? top : 8'h00));                             // RULE2
    ufield    = {3'b000, ulim_cfg[ssl_pkg::SSL_ULIM_LSB +: ssl_pkg::SSL_ULIM_W]}; // RULE16
    ulim_addr = base | (mid ? top : 8'h00) | (ufield & half);                    // RULE1
    olim_addr = base | (olim & half) | ((((olim & top) != 8'h00) && start_bottom) ? top : 8'h00); // RULE15
  end

endmodule // ssl_limit_calc

// ### design/ssl_stack_ram.sv
// One 256 by 16 stack memory with a registered read port.
// Assumes write and read requests are single-cycle strobes on clk.
`timescale 1ns/1ps
module ssl_stack_ram (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        we,
  input  wire logic [7:0]  waddr,
  input  wire logic [15:0] wdata,
  input  wire logic        re,
  input  wire logic [7:0]  raddr,
  output logic      [15:0] rdata_r
);

  logic [15:0] mem [ssl_pkg::SSL_DEPTH];
  logic [15:0] rdata_nxt;

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  // Array carries no reset so it maps onto a plain memory
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read data holds until the next pop
  always_comb begin
    rdata_nxt = re ? mem[raddr] : rdata_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

endmodule // ssl_stack_ram

// ### design/ssl_ctrl.sv
// Substack limit controller: pointers, limit registers, error flags, stack memories.
// Assumes the core drives push/pop and the register port on the same clock.
`timescale 1ns/1ps
module ssl_ctrl (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [4:0]  asic_addr,
  input  wire logic        asic_wr,
  input  wire logic        asic_rd,
  input  wire logic [15:0] asic_wdata,
  output logic      [15:0] asic_rdata,
  input  wire logic        ps_push,
  input  wire logic        ps_pop,
  input  wire logic [15:0] ps_wdata,
  output logic      [15:0] ps_rdata,
  input  wire logic        rs_push,
  input  wire logic        rs_pop,
  input  wire logic [15:0] rs_wdata,
  output logic      [15:0] rs_rdata,
  output logic             ps_underflow,
  output logic             rs_underflow,
  output logic             ps_overflow,
  output logic             rs_overflow,
  output logic             fatal_error
);

  localparam int BW = ssl_pkg::SSL_BYTE_W;

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [7:0]  ptr_r     [ssl_pkg::SSL_NSTACK];
  logic [7:0]  ptr_nxt   [ssl_pkg::SSL_NSTACK];
  logic [15:0] ulim_r;
  logic [15:0] ulim_nxt;
  logic [15:0] olim_r;
  logic [15:0] olim_nxt;
  logic        reload_r;
  logic        reload_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic        udf_r     [ssl_pkg::SSL_NSTACK];
  logic        udf_nxt   [ssl_pkg::SSL_NSTACK];
  logic        ovf_r     [ssl_pkg::SSL_NSTACK];
  logic        ovf_nxt   [ssl_pkg::SSL_NSTACK];
  logic        fat_r     [ssl_pkg::SSL_NSTACK];
  logic        fat_nxt   [ssl_pkg::SSL_NSTACK];
  logic        fatal_r;
  logic        fatal_nxt;

  // ---------------------------------------------------------------
  // Per-stack derived values
  // ---------------------------------------------------------------
  logic        push      [ssl_pkg::SSL_NSTACK];
  logic        pop       [ssl_pkg::SSL_NSTACK];
  logic        push_go   [ssl_pkg::SSL_NSTACK];
  logic        pop_go    [ssl_pkg::SSL_NSTACK];
  logic [15:0] wdat      [ssl_pkg::SSL_NSTACK];
  logic [15:0] rdat      [ssl_pkg::SSL_NSTACK];
  logic [7:0]  mask      [ssl_pkg::SSL_NSTACK];
  logic [7:0]  start_loc [ssl_pkg::SSL_NSTACK];
  logic [7:0]  fat_lim   [ssl_pkg::SSL_NSTACK];
  logic [7:0]  ulim_addr [ssl_pkg::SSL_NSTACK];
  logic [7:0]  olim_addr [ssl_pkg::SSL_NSTACK];
  logic [7:0]  rd_addr   [ssl_pkg::SSL_NSTACK];
  logic [7:0]  inc_addr  [ssl_pkg::SSL_NSTACK];

  logic        wr_ptr;
  logic        wr_ulim;
  logic        wr_olim;

  // Register port decode; every access is a whole 16-bit word
  assign wr_ptr  = asic_wr && (asic_addr == ssl_pkg::SSL_ADDR_PTR);
  assign wr_ulim = asic_wr && (asic_addr == ssl_pkg::SSL_ADDR_ULIM);   // RULE16
  assign wr_olim = asic_wr && (asic_addr == ssl_pkg::SSL_ADDR_OLIM);

  // Core strobes gathered per stack
  assign push[0] = ps_push;
  assign push[1] = rs_push;
  assign pop[0]  = ps_pop;
  assign pop[1]  = rs_pop;
  assign wdat[0] = ps_wdata;
  assign wdat[1] = rs_wdata;

  // ---------------------------------------------------------------
  // Limit derivation and stack memories
  // ---------------------------------------------------------------
  for (genvar s = 0; s < ssl_pkg::SSL_NSTACK; s++) begin : g_stack
    ssl_limit_calc u_lim (
      .ptr       (ptr_r[s]),
      .ulim_cfg  (ulim_r[s*BW +: BW]),
      .olim      (olim_r[s*BW +: BW]),
      .mask      (mask[s]),
      .start_loc (start_loc[s]),
      .fatal_lim (fat_lim[s]),
      .ulim_addr (ulim_addr[s]),
      .olim_addr (olim_addr[s])
    );

    // Pointer writes and reloads take the cycle; a push beats a pop
    assign push_go[s] = push[s] && !wr_ptr && !reload_r;
    assign pop_go[s]  = pop[s] && !push[s] && !wr_ptr && !reload_r;

    // Read address is one below the pointer, wrapping inside the substack
    assign rd_addr[s]  = (ptr_r[s] & ~mask[s]) | ((ptr_r[s] - ssl_pkg::SSL_ONE) & mask[s]);  // RULE5 RULE9
    assign inc_addr[s] = (ptr_r[s] & ~mask[s]) | ((ptr_r[s] + ssl_pkg::SSL_ONE) & mask[s]);  // RULE4 RULE9

    ssl_stack_ram u_ram (
      .clk     (clk),
      .rst_n   (rst_n),
      .we      (push_go[s]),
      .waddr   (ptr_r[s]),
      .wdata   (wdat[s]),
      .re      (pop_go[s]),
      .raddr   (rd_addr[s]),
      .rdata_r (rdat[s])
    );
  end

  // ---------------------------------------------------------------
  // Pointers
  // ---------------------------------------------------------------
  // Software value first, then the start reload, then push or pop
  always_comb begin
    reload_nxt = wr_ulim;
    for (int s = 0; s < ssl_pkg::SSL_NSTACK; s++) begin
      ptr_nxt[s] = ptr_r[s];
      if (wr_ptr) begin
        ptr_nxt[s] = asic_wdata[s*BW +: BW];                  // RULE10 RULE8
      end else if (reload_r) begin
        ptr_nxt[s] = start_loc[s];                            // RULE12 RULE13 RULE14
      end else if (push_go[s]) begin
        ptr_nxt[s] = inc_addr[s];                             // RULE4
      end else if (pop_go[s]) begin
        ptr_nxt[s] = rd_addr[s];                              // RULE5
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_r[0] <= ssl_pkg::SSL_PTR_RST;
      ptr_r[1] <= ssl_pkg::SSL_PTR_RST;
      reload_r <= 1'b0;
    end else begin
      ptr_r[0] <= ptr_nxt[0];
      ptr_r[1] <= ptr_nxt[1];
      reload_r <= reload_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Limit and configuration registers
  // ---------------------------------------------------------------
  // Overflow limits are write-only, config is read-write
  always_comb begin
    ulim_nxt = wr_ulim ? asic_wdata : ulim_r;                 // RULE7 RULE11 RULE16
    olim_nxt = wr_olim ? asic_wdata : olim_r;                 // RULE17
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ulim_r <= ssl_pkg::SSL_ULIM_RST;
      olim_r <= ssl_pkg::SSL_OLIM_RST;
    end else begin
      ulim_r <= ulim_nxt;
      olim_r <= olim_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Error flags
  // ---------------------------------------------------------------
  // A pointer write clears, but an event in the same cycle still sets
  always_comb begin
    fatal_nxt = 1'b0;
    for (int s = 0; s < ssl_pkg::SSL_NSTACK; s++) begin
      udf_nxt[s] = wr_ptr ? 1'b0 : udf_r[s];                  // RULE3
      ovf_nxt[s] = wr_ptr ? 1'b0 : ovf_r[s];                  // RULE3
      fat_nxt[s] = wr_ptr ? 1'b0 : fat_r[s];                  // RULE3 RULE18
      if (pop[s] && !push[s] && (rd_addr[s] < ulim_addr[s])) begin
        udf_nxt[s] = 1'b1;                                    // RULE1
      end
      if (push[s] && (ptr_r[s] == olim_addr[s])) begin
        ovf_nxt[s] = 1'b1;                                    // RULE15
      end
      if ((push[s] && (ptr_r[s] == fat_lim[s])) ||
          (pop[s] && !push[s] && (rd_addr[s] == fat_lim[s]))) begin
        fat_nxt[s] = 1'b1;                                    // RULE2
      end
      fatal_nxt = fatal_nxt | fat_nxt[s];                     // RULE18
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      udf_r[0] <= 1'b0;
      udf_r[1] <= 1'b0;
      ovf_r[0] <= 1'b0;
      ovf_r[1] <= 1'b0;
      fat_r[0] <= 1'b0;
      fat_r[1] <= 1'b0;
      fatal_r  <= 1'b0;
    end else begin
      udf_r[0] <= udf_nxt[0];
      udf_r[1] <= udf_nxt[1];
      ovf_r[0] <= ovf_nxt[0];
      ovf_r[1] <= ovf_nxt[1];
      fat_r[0] <= fat_nxt[0];
      fat_r[1] <= fat_nxt[1];
      fatal_r  <= fatal_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Register read data
  // ---------------------------------------------------------------
  // Write-only and unmapped addresses read as zero; data holds between reads
  always_comb begin
    rdata_nxt = rdata_r;
    if (asic_rd) begin
      case (asic_addr)
        ssl_pkg::SSL_ADDR_PTR:  rdata_nxt = {ptr_r[1], ptr_r[0]};
        ssl_pkg::SSL_ADDR_ULIM: rdata_nxt = ulim_r;            // RULE16
        default:                rdata_nxt = 16'h0000;          // RULE17
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign asic_rdata   = rdata_r;
  assign ps_rdata     = rdat[0];
  assign rs_rdata     = rdat[1];
  assign ps_underflow = udf_r[0];
  assign rs_underflow = udf_r[1];
  assign ps_overflow  = ovf_r[0];
  assign rs_overflow  = ovf_r[1];
  assign fatal_error  = fatal_r;

endmodule // ssl_ctrl

// ### verification/ssl_ctrl_sva.sv
// Checker for the substack limit controller ports.
// Assumes a single clock and asynchronous active-low reset.
`timescale 1ns/1ps
module ssl_ctrl_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [4:0]  asic_addr,
  input wire logic        asic_wr,
  input wire logic        asic_rd,
  input wire logic [15:0] asic_wdata,
  input wire logic [15:0] asic_rdata,
  input wire logic        ps_push,
  input wire logic        ps_pop,
  input wire logic [15:0] ps_wdata,
  input wire logic [15:0] ps_rdata,
  input wire logic        rs_push,
  input wire logic        rs_pop,
  input wire logic [15:0] rs_wdata,
  input wire logic [15:0] rs_rdata,
  input wire logic        ps_underflow,
  input wire logic        rs_underflow,
  input wire logic        ps_overflow,
  input wire logic        rs_overflow,
  input wire logic        fatal_error
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic any_op;
  logic reload_r;
  assign any_op = ps_push | ps_pop | rs_push | rs_pop;
  // Config write implies a pointer reload in the next cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) reload_r <= 1'b0;
    else reload_r <= asic_wr && (asic_addr == ssl_pkg::SSL_ADDR_ULIM);
  end
  sequence ptr_wr; asic_wr && (asic_addr == ssl_pkg::SSL_ADDR_PTR); endsequence
  sequence ptr_rd; asic_rd && !asic_wr && (asic_addr == ssl_pkg::SSL_ADDR_PTR); endsequence
  // Push, one quiet cycle, then pop of the same stack
  sequence push_pop;
    ps_push && !ps_pop && !asic_wr && !reload_r ##1 !ps_push && !ps_pop && !asic_wr ##1 ps_pop && !ps_push && !asic_wr;
  endsequence
  // Pointer write, one quiet cycle, then pointer read
  sequence ptr_wr_rd;
    ptr_wr ##1 !any_op && !asic_wr ##1 ptr_rd;
  endsequence
  chk_err_clear: assert property (ptr_wr ##0 !any_op |=>
    !fatal_error && !ps_overflow && !ps_underflow && !rs_overflow && !rs_underflow) else $error("flag not cleared");
  chk_fatal_hold: assert property (fatal_error && !asic_wr |=> fatal_error) else $error("fatal dropped");
  chk_ovf_cause: assert property ($rose(ps_overflow) |-> $past(ps_push)) else $error("overflow w/o push");
  chk_uflow_cause: assert property ($rose(ps_underflow) |-> $past(ps_pop)) else $error("underflow w/o pop");
  chk_fatal_cause: assert property ($rose(fatal_error) |-> $past(any_op)) else $error("fatal w/o access");
  chk_olim_wo: assert property (asic_rd && asic_addr == ssl_pkg::SSL_ADDR_OLIM |=>
    asic_rdata == 16'h0000) else $error("overflow limits readable");
  chk_ptr_back: assert property (ptr_wr_rd |=> asic_rdata == $past(asic_wdata, 3))
    else $error("pointer readback wrong");
  chk_push_pop: assert property (push_pop |=> ps_rdata == $past(ps_wdata, 3))
    else $error("pop data wrong");
endmodule // ssl_ctrl_chk
bind ssl_ctrl ssl_ctrl_chk i_chk (.clk(clk), .rst_n(rst_n), .asic_addr(asic_addr), .asic_wr(asic_wr),
  .asic_rd(asic_rd), .asic_wdata(asic_wdata), .asic_rdata(asic_rdata), .ps_push(ps_push), .ps_pop(ps_pop),
  .ps_wdata(ps_wdata), .ps_rdata(ps_rdata), .rs_push(rs_push), .rs_pop(rs_pop), .rs_wdata(rs_wdata),
  .rs_rdata(rs_rdata), .ps_underflow(ps_underflow), .rs_underflow(rs_underflow), .ps_overflow(ps_overflow),
  .rs_overflow(rs_overflow), .fatal_error(fatal_error));

// ### verification/ssl_core_model.sv
// Processor core model issuing push and pop strobes.
// Assumes callers start each task 1 ns after a rising edge.
`timescale 1ns/1ps
module ssl_core_model (
  input  wire logic        clk,
  input  wire logic [15:0] ps_rdata,
  input  wire logic [15:0] rs_rdata,
  output logic             ps_push,
  output logic             ps_pop,
  output logic [15:0]      ps_wdata,
  output logic             rs_push,
  output logic             rs_pop,
  output logic [15:0]      rs_wdata
);
  initial begin
    {ps_push, ps_pop, rs_push, rs_pop} = 4'h0;
    ps_wdata = 16'h0000;
    rs_wdata = 16'h0000;
  end
  // Data is inverted after use so a stale value never looks valid
  // One idle edge after each call, so a following call never re-drives a strobe in the same step
  task automatic push(input logic s, input logic [15:0] d);
    if (s) begin rs_wdata = d; rs_push = 1'b1; end else begin ps_wdata = d; ps_push = 1'b1; end
    @(posedge clk);
    #1 {ps_push, rs_push} = 2'b00;
    if (s) rs_wdata = ~d; else ps_wdata = ~d;
    @(posedge clk);
    #1;
  endtask
  task automatic pop(input logic s, output logic [15:0] d);
    if (s) rs_pop = 1'b1; else ps_pop = 1'b1;
    @(posedge clk);
    #1 {ps_pop, rs_pop} = 2'b00;
    d = s ? rs_rdata : ps_rdata;
    @(posedge clk);
    #1;
  endtask
endmodule // ssl_core_model

// ### verification/substack_limit_controller_tb.sv
// Self-checking bench for the substack limit controller.
// Assumes fixed one-edge latencies on the register and stack ports.
`timescale 1ns/1ps
module substack_limit_controller_tb;
  logic        clk, rst_n, asic_wr, asic_rd, ps_push, ps_pop, rs_push, rs_pop;
  logic        ps_underflow, rs_underflow, ps_overflow, rs_overflow, fatal_error;
  logic [4:0]  asic_addr;
  logic [15:0] asic_wdata, asic_rdata, ps_wdata, ps_rdata, rs_wdata, rs_rdata, v;
  int          err_total, samples_checked;
  initial begin clk = 0; forever #5 clk = ~clk; end
  ssl_ctrl i_ssl_ctrl (.clk(clk), .rst_n(rst_n), .asic_addr(asic_addr), .asic_wr(asic_wr), .asic_rd(asic_rd),
    .asic_wdata(asic_wdata), .asic_rdata(asic_rdata), .ps_push(ps_push), .ps_pop(ps_pop), .ps_wdata(ps_wdata),
    .ps_rdata(ps_rdata), .rs_push(rs_push), .rs_pop(rs_pop), .rs_wdata(rs_wdata), .rs_rdata(rs_rdata),
    .ps_underflow(ps_underflow), .rs_underflow(rs_underflow), .ps_overflow(ps_overflow),
    .rs_overflow(rs_overflow), .fatal_error(fatal_error));
  ssl_core_model i_core (.clk(clk), .ps_rdata(ps_rdata), .rs_rdata(rs_rdata), .ps_push(ps_push), .ps_pop(ps_pop),
    .ps_wdata(ps_wdata), .rs_push(rs_push), .rs_pop(rs_pop), .rs_wdata(rs_wdata));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin err_total++; $display("[FAIL] %s expected %h seen %h", what, exp, seen); end
  endtask
  // Each access ends with one idle edge so back-to-back calls never re-drive a signal in one step
  task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
    asic_addr = a; asic_wdata = d; asic_wr = 1'b1;
    @(posedge clk);
    #1 asic_wr = 1'b0; asic_wdata = ~d;
    @(posedge clk);
    #1;
  endtask
  task automatic reg_rd(input logic [4:0] a, output logic [15:0] d);
    asic_addr = a; asic_rd = 1'b1;
    @(posedge clk);
    #1 asic_rd = 1'b0; d = asic_rdata;
    @(posedge clk);
    #1;
  endtask
  task automatic idle; @(posedge clk); #1; endtask
  task automatic conclude;
    if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_regs;
    reg_wr(ssl_pkg::SSL_ADDR_PTR, 16'h2345); reg_rd(ssl_pkg::SSL_ADDR_PTR, v); check("ptr", v, 16'h2345);
    reg_rd(ssl_pkg::SSL_ADDR_OLIM, v); check("olim read", v, 16'h0000);
    reg_wr(ssl_pkg::SSL_ADDR_ULIM, 16'hfa5b); reg_rd(ssl_pkg::SSL_ADDR_ULIM, v); check("cfg", v, 16'hfa5b);
  endtask
  // Substack 2 of 32 words: overflow at 0x5e, fatal at 0x5f, underflow below 0x45
  task automatic test_substack;
    reg_wr(ssl_pkg::SSL_ADDR_ULIM, 16'h0029);
    reg_wr(ssl_pkg::SSL_ADDR_OLIM, 16'h001e);
    reg_wr(ssl_pkg::SSL_ADDR_PTR, 16'h005e);
    i_core.push(1'b0, 16'h1111);
    i_core.push(1'b0, 16'h2222);
    reg_rd(ssl_pkg::SSL_ADDR_PTR, v); check("wrap ptr", v, 16'h0040);
    check("ovf", ps_overflow, 16'h0001);
    check("fatal", fatal_error, 16'h0001);
    i_core.pop(1'b0, v); check("pop wrap", v, 16'h2222);
    i_core.push(1'b0, 16'h3333);
    i_core.pop(1'b0, v); check("pop c", v, 16'h3333);
    i_core.pop(1'b0, v); check("pop a", v, 16'h1111);
    check("no uflow", ps_underflow, 16'h0000);
    reg_wr(ssl_pkg::SSL_ADDR_PTR, 16'h0044);
    check("ovf clr", ps_overflow, 16'h0000);
    check("fatal clr", fatal_error, 16'h0000);
    i_core.pop(1'b0, v); idle;
    check("uflow", ps_underflow, 16'h0001);
  endtask
  // Start location per size code on both stacks, then the two bottom-start cases
  task automatic test_start;
    reg_wr(ssl_pkg::SSL_ADDR_OLIM, 16'hffff);
    reg_wr(ssl_pkg::SSL_ADDR_PTR, 16'h0000);
    for (int s = 0; s < 4; s++) begin
      reg_wr(ssl_pkg::SSL_ADDR_ULIM, {2{5'h00, s[1:0], 1'b0}}); idle;
      reg_rd(ssl_pkg::SSL_ADDR_PTR, v); check("mid start", v, {2{8'h10 << s}});
    end
    reg_wr(ssl_pkg::SSL_ADDR_ULIM, 16'h0707); idle;
    reg_rd(ssl_pkg::SSL_ADDR_PTR, v); check("bottom start", v, 16'h0000);
    reg_wr(ssl_pkg::SSL_ADDR_PTR, 16'h4040);
    reg_wr(ssl_pkg::SSL_ADDR_OLIM, 16'h0000);
    reg_wr(ssl_pkg::SSL_ADDR_ULIM, 16'h0606); idle;
    reg_rd(ssl_pkg::SSL_ADDR_PTR, v); check("low olim start", v, 16'h0000);
    i_core.push(1'b1, 16'hbeef);
    reg_rd(ssl_pkg::SSL_ADDR_PTR, v); check("rs ptr", v, 16'h0100);
    check("rs ovf", rs_overflow, 16'h0001);
    i_core.pop(1'b1, v); check("rs pop", v, 16'hbeef);
    check("rs no uflow", rs_underflow, 16'h0000);
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    err_total = 0; samples_checked = 0;
    rst_n = 1'b0; asic_wr = 1'b0; asic_rd = 1'b0; asic_addr = 5'h00; asic_wdata = 16'h0000;
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    idle;
    test_regs;
    test_substack;
    test_start;
    conclude;
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    conclude;
  end
endmodule // substack_limit_controller_tb
